// ===== include/irq_ctrl_map.svh
// register offsets, field positions, vector constants for the irq controller
// assumes inclusion by both the package users and design modules
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH
`define GLOBAL_EN_OFFSET   8'h20
`define EP_EN_OFFSET       8'h21
`define CPU_STATUS_OFFSET  8'h22
`define GLOBAL_EN_MASK     8'h7F
`define EP_EN_MASK         8'h1F
`define GEN_USB_RST_BIT    0
`define GEN_TICK_FAST_BIT  1
`define GEN_TICK_SLOW_BIT  2
`define GEN_HUB_BIT        3
`define GEN_DAC_BIT        4
`define GEN_GPIO_BIT       5
`define GEN_I2C_BIT        6
`define STAT_GIE_BIT       2
`define STAT_PEND_BIT      7
`define NUM_SRC            12
`define RESET_ADDR         16'h0000
`define VEC_STRIDE_SHIFT   1
`define AXI_OKAY           2'b00
`define AXI_SLVERR         2'b10
`define NUM_GPIO           8
`endif

// ===== include/irq_ctrl_pkg.sv
// types shared by the irq controller files
// assumes the map header for widths
package irq_ctrl_pkg;
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_RESP
  } rd_state_t;
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } wr_state_t;
  typedef logic [11:0] src_vec_t;
endpackage

// ===== design/edge_sense.sv
// edge detector for one asynchronous level, two-flop synchronised
// assumes a single clock domain, async active-low reset
`timescale 1ns/10ps
module edge_sense (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // level in and detected edges
  input  wire logic level_in,
  output logic      rise,
  output logic      fall
);
  logic s1_reg;
  logic s2_reg;
  logic       s3_reg;
  logic [2:0] fill_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg   <= 1'b0;
      s2_reg   <= 1'b0;
      s3_reg   <= 1'b0;
      fill_reg <= 3'b000;
    end else begin
      s1_reg   <= level_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      fill_reg <= {fill_reg[1:0], 1'b1};
    end
  end

  // no edge until the stages hold real samples: a pin idling high after reset
  assign rise = fill_reg[2] & s2_reg & ~s3_reg;
  assign fall = fill_reg[2] & ~s2_reg & s3_reg;
endmodule // edge_sense

// ===== design/irq_controller.sv
// prioritised vectored interrupt controller with AXI4-Lite registers
// assumes the core signals instruction boundaries and ei/di/return_from_handler_instr in clk domain
//
// Overview of operation
// - writing one to an enable bit enables that source
// - global enable bits: bus reset, fast, slow timer, hub, dac, gpio, i2c
// - gpio source fires on both edges of any pin
// - endpoint enable bits 0-2 address A, bits 3-4 address B
// - reset clears both enable registers
// - each source has a pending flop set by its event until serviced
// - pending requests only when enabled; masked pending stays latched
// - service only at instruction boundary
// - servicing clears global interrupt enable, seen at status bit 2
// - acknowledge clears only the serviced pending flop
// - forced call to the serviced vector address
// - call pushes pc with carry and zero flags only
// - return restores pc and flags and sets global enable; here RETURN_INSTR only sets global enable, pc and flags are not restored
// - mask and unmask instructions touch only global enable
// - any enabled pending request shows in status bit 7; masked pending does not
// - vector 1 highest priority, vector 12 lowest
// - after reset execution starts at address zero
// - vector n sits at address 2n
// - order: reset, timers, A endpoints, B endpoints, hub, dac, gpio, i2c
// - re-enabling inside a handler allows nesting
// - hub enable gates hub request, pending kept
// - parallel port mode owns gpio vector, blocks pin events
// - bus reset event raised when single-ended-zero ends
`timescale 1ns/10ps
`include "irq_ctrl_map.svh"
module irq_controller
  import irq_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // axi4-lite write address and data
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  // axi4-lite write response
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // axi4-lite read
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // interrupt events from sources, one-cycle pulses in clk domain
  input  wire logic        TICK_FAST_EVT,
  input  wire logic        TICK_SLOW_EVT,
  input  wire logic [4:0]  EP_EVT,
  input  wire logic        HUB_EVT,
  input  wire logic        DAC_EVT,
  input  wire logic        I2C_EVT,
  input  wire logic        PARALLEL_EVT,
  // pins from outside the clock domain
  input  wire logic        UPSTREAM_SE0,
  input  wire logic [7:0]  GPIO_PIN,
  input  wire logic        PARALLEL_MODE,
  // core interface
  input  wire logic        INSTR_DONE,
  input  wire logic        MASK_INSTR,
  input  wire logic        UNMASK_INSTR,
  input  wire logic        RETURN_INSTR,
  input  wire logic [15:0] CUR_PC,
  input  wire logic        CARRY_FLAG,
  input  wire logic        ZERO_FLAG,
  // forced call and stack push
  output logic             CALL_REQ,
  output logic [15:0]      CALL_ADDR,
  output logic [15:0]      PUSH_PC,
  output logic             PUSH_CARRY,
  output logic             PUSH_ZERO,
  output logic [15:0]      RESET_VECTOR,
  // status visible to the core
  output logic             GIE,
  output logic             IRQ_PENDING
);
  logic [7:0]  global_en_reg;
  logic [7:0]  ep_en_reg;
  src_vec_t    pending_reg;
  src_vec_t    set_vec;
  src_vec_t    enable_vec;
  src_vec_t    request_vec;
  src_vec_t    grant_vec;
  logic        gie_reg;
  logic [3:0]  grant_idx;
  logic        take;
  logic        se0_s1_reg;
  logic        se0_s2_reg;
  logic        se0_s3_reg;
  logic        bus_reset_evt;
  logic [7:0]  gpio_rise;
  logic [7:0]  gpio_fall;
  logic        gpio_evt;
  logic        vector_evt_gpio;
  logic        mode_s1_reg;
  logic        mode_s2_reg;
  logic [15:0] call_addr_reg;
  logic        call_req_reg;
  logic [15:0] push_pc_reg;
  logic        push_c_reg;
  logic        push_z_reg;
  wr_state_t   wr_state_reg;
  rd_state_t   rd_state_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  logic        w_lane0_reg;
  logic [1:0]  bresp_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [7:0]  status_byte;

  // upstream se0 synchroniser and release detection
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      se0_s1_reg <= 1'b0;
      se0_s2_reg <= 1'b0;
      se0_s3_reg <= 1'b0;
      mode_s1_reg <= 1'b0;
      mode_s2_reg <= 1'b0;
    end else begin
      se0_s1_reg <= UPSTREAM_SE0;
      se0_s2_reg <= se0_s1_reg;
      se0_s3_reg <= se0_s2_reg;
      mode_s1_reg <= PARALLEL_MODE;
      mode_s2_reg <= mode_s1_reg;
    end
  end
  assign bus_reset_evt = se0_s3_reg & ~se0_s2_reg;

  // per-pin edge detection
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_GPIO; gi++) begin : g_pin
      edge_sense u_edge (
        .clk      (CLK),
        .rst_b    (RST_B),
        .level_in (GPIO_PIN[gi]),
        .rise     (gpio_rise[gi]),
        .fall     (gpio_fall[gi])
      );
    end
  endgenerate
  assign gpio_evt = |(gpio_rise | gpio_fall);
  assign vector_evt_gpio = mode_s2_reg ? PARALLEL_EVT : gpio_evt;

  // event vector in vector order, bit 0 = vector 1
  always_comb begin
    set_vec = {I2C_EVT, vector_evt_gpio, DAC_EVT, HUB_EVT, EP_EVT,
               TICK_SLOW_EVT, TICK_FAST_EVT, bus_reset_evt};
  end

  // enable gating per vector; gpio bit alone gates parallel port mode
  always_comb begin
    enable_vec = {global_en_reg[`GEN_I2C_BIT], global_en_reg[`GEN_GPIO_BIT],
                  global_en_reg[`GEN_DAC_BIT], global_en_reg[`GEN_HUB_BIT],
                  ep_en_reg[4:0], global_en_reg[`GEN_TICK_SLOW_BIT],
                  global_en_reg[`GEN_TICK_FAST_BIT],
                  global_en_reg[`GEN_USB_RST_BIT]};
  end
  assign request_vec = pending_reg & enable_vec;

  // fixed priority: lowest index wins, one grant only
  always_comb begin
    grant_vec = '0;
    grant_idx = 4'h0;
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
      if (request_vec[i]) begin
        grant_vec = src_vec_t'(1) << i;
        grant_idx = 4'(i + 1);
      end
    end
  end

  assign take = INSTR_DONE & gie_reg & (|request_vec);

  // pending flops: set wins over the acknowledge clear
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pending_reg <= '0;
    end else begin
      pending_reg <= (pending_reg & ~(take ? grant_vec : '0)) | set_vec;
    end
  end

  // global interrupt enable of the core
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      gie_reg <= 1'b0;
    end else if (take) begin
      gie_reg <= 1'b0;
    end else if (MASK_INSTR) begin
      gie_reg <= 1'b0;
    end else if (UNMASK_INSTR | RETURN_INSTR) begin
      gie_reg <= 1'b1;
    end
  end

  // forced call and push frame
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      call_req_reg  <= 1'b0;
      call_addr_reg <= `RESET_ADDR;
      push_pc_reg   <= 16'h0000;
      push_c_reg    <= 1'b0;
      push_z_reg    <= 1'b0;
    end else begin
      call_req_reg <= take;
      if (take) begin
        call_addr_reg <= {12'h000, grant_idx} << `VEC_STRIDE_SHIFT;
        push_pc_reg   <= CUR_PC;
        push_c_reg    <= CARRY_FLAG;
        push_z_reg    <= ZERO_FLAG;
      end
    end
  end

  assign CALL_REQ     = call_req_reg;
  assign CALL_ADDR    = call_addr_reg;
  assign PUSH_PC      = push_pc_reg;
  assign PUSH_CARRY   = push_c_reg;
  assign PUSH_ZERO    = push_z_reg;
  assign RESET_VECTOR = `RESET_ADDR;
  assign GIE          = gie_reg;
  assign IRQ_PENDING  = |request_vec;

  // status byte: pending at bit 7, global enable at bit 2
  always_comb begin
    status_byte = 8'h00;
    status_byte[`STAT_PEND_BIT] = |request_vec;
    status_byte[`STAT_GIE_BIT]  = gie_reg;
  end

  // axi write channel capture, either order
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_lane0_reg <= 1'b0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= AWADDR;
      end else if (wr_state_reg == WR_RESP && BREADY) begin
        aw_have_reg <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_have_reg <= 1'b1;
        w_data_reg <= WDATA;
        w_lane0_reg <= WSTRB[0];
      end else if (wr_state_reg == WR_RESP && BREADY) begin
        w_have_reg <= 1'b0;
      end
    end
  end
  assign AWREADY = (wr_state_reg == WR_IDLE) && !aw_have_reg;
  assign WREADY  = (wr_state_reg == WR_IDLE) && !w_have_reg;

  // write commit and enable registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_state_reg  <= WR_IDLE;
      global_en_reg <= 8'h00;
      ep_en_reg     <= 8'h00;
      bresp_reg     <= `AXI_OKAY;
    end else begin
      unique case (wr_state_reg)
        WR_IDLE: begin
          if (aw_have_reg && w_have_reg) begin
            wr_state_reg <= WR_RESP;
            bresp_reg    <= `AXI_OKAY;
            if ({2'b00, aw_addr_reg[7:2]} == `GLOBAL_EN_OFFSET) begin
              if (w_lane0_reg) begin
                global_en_reg <= w_data_reg[7:0] & `GLOBAL_EN_MASK;
              end
            end else if ({2'b00, aw_addr_reg[7:2]} == `EP_EN_OFFSET) begin
              if (w_lane0_reg) begin
                ep_en_reg <= w_data_reg[7:0] & `EP_EN_MASK;
              end
            end else if ({2'b00, aw_addr_reg[7:2]} != `CPU_STATUS_OFFSET) begin
              bresp_reg <= `AXI_SLVERR;
            end
          end
        end
        WR_RESP: begin
          if (BREADY) begin
            wr_state_reg <= WR_IDLE;
          end
        end
      endcase
    end
  end
  assign BVALID = (wr_state_reg == WR_RESP);
  assign BRESP  = bresp_reg;

  // read channel
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rd_state_reg <= RD_IDLE;
      rdata_reg    <= 32'h0000_0000;
      rresp_reg    <= `AXI_OKAY;
    end else begin
      unique case (rd_state_reg)
        RD_IDLE: begin
          if (ARVALID) begin
            rd_state_reg <= RD_RESP;
            rresp_reg    <= `AXI_OKAY;
            rdata_reg    <= 32'h0000_0000;
            if ({2'b00, ARADDR[7:2]} == `GLOBAL_EN_OFFSET) begin
              rdata_reg[7:0] <= global_en_reg;
            end else if ({2'b00, ARADDR[7:2]} == `EP_EN_OFFSET) begin
              rdata_reg[7:0] <= ep_en_reg;
            end else if ({2'b00, ARADDR[7:2]} == `CPU_STATUS_OFFSET) begin
              rdata_reg[7:0] <= status_byte;
            end else begin
              rresp_reg <= `AXI_SLVERR;
            end
          end
        end
        RD_RESP: begin
          if (RREADY) begin
            rd_state_reg <= RD_IDLE;
          end
        end
      endcase
    end
  end
  assign ARREADY = (rd_state_reg == RD_IDLE);
  assign RVALID  = (rd_state_reg == RD_RESP);
  assign RDATA   = rdata_reg;
  assign RRESP   = rresp_reg;
endmodule // irq_controller

// ===== tb/irq_controller_assertions.sv
// checker for the core-side ports of the irq controller
// assumes it is bound onto irq_controller, one clock, async low reset
`timescale 1ns/10ps
module irq_controller_chk (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST_B,
  // core side
  input wire logic        INSTR_DONE,
  input wire logic        MASK_INSTR,
  input wire logic        UNMASK_INSTR,
  input wire logic        RETURN_INSTR,
  input wire logic [15:0] CUR_PC,
  input wire logic        CARRY_FLAG,
  input wire logic        ZERO_FLAG,
  input wire logic        CALL_REQ,
  input wire logic [15:0] CALL_ADDR,
  input wire logic [15:0] PUSH_PC,
  input wire logic        PUSH_CARRY,
  input wire logic        PUSH_ZERO,
  input wire logic [15:0] RESET_VECTOR,
  input wire logic        GIE,
  input wire logic        IRQ_PENDING
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence s_take; INSTR_DONE && GIE && IRQ_PENDING; endsequence
  sequence s_call; CALL_REQ && !GIE; endsequence
  property p_take; s_take |=> s_call; endproperty
  property p_boundary; !(INSTR_DONE && GIE && IRQ_PENDING) |=> !CALL_REQ; endproperty
  property p_push; s_take |=> PUSH_PC == $past(CUR_PC) && PUSH_CARRY == $past(CARRY_FLAG)
    && PUSH_ZERO == $past(ZERO_FLAG); endproperty
  property p_vec; CALL_REQ |-> !CALL_ADDR[0] && CALL_ADDR >= 16'h0002 && CALL_ADDR <= 16'h0018;
  endproperty
  property p_mask; MASK_INSTR |=> !GIE; endproperty
  property p_unmask; (UNMASK_INSTR || RETURN_INSTR) && !MASK_INSTR
    && !(INSTR_DONE && GIE && IRQ_PENDING) |=> GIE; endproperty
  property p_gie_hold; !(MASK_INSTR || UNMASK_INSTR || RETURN_INSTR || INSTR_DONE)
    |=> $stable(GIE); endproperty
  property p_rst_vec; RESET_VECTOR == 16'h0000
    && (!$rose(RST_B) || (CALL_ADDR == 16'h0000 && !CALL_REQ)); endproperty
  property p_one_call; CALL_REQ |=> !CALL_REQ; endproperty
  a_take: assert property (p_take) else $error("no call after take");
  a_boundary: assert property (p_boundary) else $error("call off boundary");
  a_push: assert property (p_push) else $error("pushed state wrong");
  a_vec: assert property (p_vec) else $error("vector address wrong");
  a_mask: assert property (p_mask) else $error("mask left enable set");
  a_unmask: assert property (p_unmask) else $error("enable not set");
  a_gie_hold: assert property (p_gie_hold) else $error("enable moved");
  a_rst_vec: assert property (p_rst_vec) else $error("reset vector wrong");
  a_one_call: assert property (p_one_call) else $error("two calls");
endmodule // irq_controller_chk
bind irq_controller irq_controller_chk u_chk (.CLK, .RST_B, .INSTR_DONE, .MASK_INSTR,
  .UNMASK_INSTR, .RETURN_INSTR, .CUR_PC, .CARRY_FLAG, .ZERO_FLAG, .CALL_REQ, .CALL_ADDR,
  .PUSH_PC, .PUSH_CARRY, .PUSH_ZERO, .RESET_VECTOR, .GIE, .IRQ_PENDING);

// ===== tb/core_model.sv
// processor core model: instruction boundaries, handler, return
// assumes the controller's call outputs in the same clock
`timescale 1ns/10ps
module core_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // bench control and controller side
  input  wire logic        run,
  input  wire logic        call_req,
  output logic             instr_done,
  output logic             ret_instr,
  output logic [15:0]      cur_pc,
  output logic             carry_flag,
  output logic             zero_flag
);
  logic [2:0] cnt_reg;
  logic       busy_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg    <= 3'h0;
      busy_reg   <= 1'b0;
      instr_done <= 1'b0;
      ret_instr  <= 1'b0;
      cur_pc     <= 16'h0000;
    end else begin
      cnt_reg    <= cnt_reg + 3'h1;
      instr_done <= 1'b0;
      ret_instr  <= 1'b0;
      if (call_req) begin
        busy_reg <= 1'b1;
        cnt_reg  <= 3'h0;
      end else if (busy_reg && cnt_reg == 3'h5) begin
        busy_reg  <= 1'b0;
        ret_instr <= 1'b1;
      end else if (run && !busy_reg && cnt_reg[1:0] == 2'b11) begin
        instr_done <= 1'b1;
        cur_pc     <= cur_pc + 16'h0001;
      end
    end
  end
  assign carry_flag = cur_pc[0];
  assign zero_flag  = cur_pc[1];
endmodule // core_model

// ===== tb/prioritized_vectored_irq_controller_tb_top.sv
// self-checking bench for the irq controller
// assumes core_model as far side and the bound checker
`timescale 1ns/10ps
module prioritized_vectored_irq_controller_tb_top;
  logic        CLK, RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY;
  logic        BVALID, ARREADY, RVALID, TICK_FAST_EVT, TICK_SLOW_EVT, HUB_EVT, DAC_EVT;
  logic        I2C_EVT, PARALLEL_EVT, UPSTREAM_SE0, PARALLEL_MODE, INSTR_DONE, MASK_INSTR;
  logic        UNMASK_INSTR, RETURN_INSTR, CARRY_FLAG, ZERO_FLAG, CALL_REQ, PUSH_CARRY;
  logic        PUSH_ZERO, GIE, IRQ_PENDING, run;
  logic [7:0]  AWADDR, ARADDR, GPIO_PIN;
  logic [31:0] WDATA, RDATA, rd_d;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, rd_r, wr_r;
  logic [4:0]  EP_EVT;
  logic [15:0] CUR_PC, CALL_ADDR, PUSH_PC, RESET_VECTOR;
  logic [15:0] calls[$];
  logic [11:0] m;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  irq_controller dut (.CLK, .RST_B, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
    .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
    .RREADY, .TICK_FAST_EVT, .TICK_SLOW_EVT, .EP_EVT, .HUB_EVT, .DAC_EVT, .I2C_EVT,
    .PARALLEL_EVT, .UPSTREAM_SE0, .GPIO_PIN, .PARALLEL_MODE, .INSTR_DONE, .MASK_INSTR,
    .UNMASK_INSTR, .RETURN_INSTR, .CUR_PC, .CARRY_FLAG, .ZERO_FLAG, .CALL_REQ, .CALL_ADDR,
    .PUSH_PC, .PUSH_CARRY, .PUSH_ZERO, .RESET_VECTOR, .GIE, .IRQ_PENDING);
  core_model u_core (.clk(CLK), .rst_b(RST_B), .run(run), .call_req(CALL_REQ),
    .instr_done(INSTR_DONE), .ret_instr(RETURN_INSTR), .cur_pc(CUR_PC),
    .carry_flag(CARRY_FLAG), .zero_flag(ZERO_FLAG));
  always #10 CLK = ~CLK;
  always @(negedge CLK) if (CALL_REQ === 1'b1) calls.push_back(CALL_ADDR);
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  task final_report();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk_data(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function logic [15:0] vec_addr(input int v);
    return 16'(v << 1);
  endfunction
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge CLK);
    {AWADDR, WDATA, AWVALID, WVALID, BREADY} <= {a, d, 3'b111};
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(negedge CLK);
      aw = aw && AWREADY !== 1'b1;
      w = w && WREADY !== 1'b1;
      @(posedge CLK);
      if (!aw) AWVALID <= 1'b0;
      if (!w) WVALID <= 1'b0;
    end
    do @(negedge CLK); while (BVALID !== 1'b1);
    wr_r = BRESP;
    @(posedge CLK);
    BREADY <= 1'b0;
  endtask
  task axi_rd(input logic [7:0] a);
    @(posedge CLK);
    {ARADDR, ARVALID, RREADY} <= {a, 2'b11};
    do @(negedge CLK); while (ARREADY !== 1'b1);
    @(posedge CLK);
    ARVALID <= 1'b0;
    do @(negedge CLK); while (RVALID !== 1'b1);
    {rd_d, rd_r} = {RDATA, RRESP};
    @(posedge CLK);
    RREADY <= 1'b0;
  endtask
  task instr(input logic msk);
    @(posedge CLK);
    {MASK_INSTR, UNMASK_INSTR} <= {msk, !msk};
    @(posedge CLK);
    {MASK_INSTR, UNMASK_INSTR} <= 2'b00;
  endtask
  // vector n is bit n-1; bus reset fires on release of se0
  task fire(input logic [11:0] v);
    @(posedge CLK);
    {I2C_EVT, DAC_EVT, HUB_EVT, EP_EVT, TICK_SLOW_EVT, TICK_FAST_EVT} <= {v[11], v[9:1]};
    UPSTREAM_SE0 <= v[0];
    GPIO_PIN <= GPIO_PIN ^ {7'h00, v[10]};
    @(posedge CLK);
    {I2C_EVT, DAC_EVT, HUB_EVT, EP_EVT, TICK_SLOW_EVT, TICK_FAST_EVT, UPSTREAM_SE0} <= '0;
    repeat (6) @(posedge CLK);
  endtask
  task expect_calls(input logic [11:0] v);
    int k;
    k = 0;
    repeat (200) @(posedge CLK);
    for (int i = 1; i <= 12; i++) if (v[i-1]) begin
      chk_data(32'(k < calls.size() ? calls[k] : 16'hffff), 32'(vec_addr(i)));
      k++;
    end
    chk_data(32'(calls.size()), 32'(k));
    calls.delete();
  endtask
  initial begin
    {CLK, RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWADDR, ARADDR, WDATA} = '0;
    {TICK_FAST_EVT, TICK_SLOW_EVT, HUB_EVT, DAC_EVT, I2C_EVT, PARALLEL_EVT, EP_EVT} = '0;
    {UPSTREAM_SE0, PARALLEL_MODE, MASK_INSTR, UNMASK_INSTR, GPIO_PIN} = '0;
    WSTRB = 4'hf;
    run = 1'b1;
    void'($urandom(32'hb4ce_8885));
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      axi_rd(8'h80 + 8'(4 * i));
      chk_data(rd_d, 32'h0000_0000);
    end
    $display("test reset done");
    axi_wr(8'h80, 32'hffff_ffff);
    chk_resp(wr_r, 2'b00);
    axi_rd(8'h80);
    chk_data(rd_d, 32'h0000_007f);
    chk_resp(rd_r, 2'b00);
    axi_wr(8'h84, 32'hffff_ffff);
    axi_rd(8'h84);
    chk_data(rd_d, 32'h0000_001f);
    axi_rd(8'h8c);
    chk_resp(rd_r, 2'b10);
    axi_wr(8'h8c, 32'h0000_0001);
    chk_resp(wr_r, 2'b10);
    axi_wr(8'h88, 32'h0000_00ff);
    chk_resp(wr_r, 2'b00);
    axi_rd(8'h88);
    chk_data(rd_d, 32'h0000_0000);
    $display("test registers done");
    axi_wr(8'h80, 32'h0000_0077);
    instr(1'b0);
    fire(12'h100);
    expect_calls(12'h000);
    instr(1'b1);
    axi_wr(8'h80, 32'h0000_007f);
    axi_rd(8'h88);
    chk_data(rd_d, 32'h0000_0080);
    instr(1'b0);
    expect_calls(12'h100);
    axi_rd(8'h88);
    chk_data(rd_d, 32'h0000_0004);
    $display("test mask done");
    for (int i = 0; i < 6; i++) begin
      m = (i == 0) ? 12'hfff : 12'($urandom);
      run <= 1'b0;
      fire(m);
      run <= 1'b1;
      expect_calls(m);
    end
    $display("test priority done");
    PARALLEL_MODE <= 1'b1;
    repeat (4) @(posedge CLK);
    fire(12'h400);
    expect_calls(12'h000);
    PARALLEL_EVT <= 1'b1;
    @(posedge CLK);
    PARALLEL_EVT <= 1'b0;
    expect_calls(12'h400);
    $display("test parallel done");
    PARALLEL_MODE <= 1'b0;
    GPIO_PIN <= 8'h01;
    @(posedge CLK);
    RST_B <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1;
    axi_rd(8'h80);
    chk_data(rd_d, 32'h0000_0000);
    axi_rd(8'h84);
    chk_data(rd_d, 32'h0000_0000);
    axi_wr(8'h80, 32'h0000_0020);
    axi_rd(8'h88);
    chk_data(rd_d, 32'h0000_0000);
    $display("test second reset done");
    final_report();
  end
endmodule // prioritized_vectored_irq_controller_tb_top
